// file: rtl/ait_top.sv
// Interlock contact and transient trigger input control
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module ait_top (
  input  wire logic                        CLOCK_I,
  input  wire logic                        RST_I,
  input  wire logic                        INTERLOCK_I,
  input  wire logic                        TRIGGER_I,
  input  wire logic [ait_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [ait_pkg::DATA_W-1:0]  WDATA_I,
  input  wire logic                        WR_I,
  input  wire logic                        RD_I,
  output logic      [ait_pkg::DATA_W-1:0]  RDATA_O,
  output logic                             OUTPUT_ON_O,
  output logic                             FAULT_O,
  output logic                             PROG_START_O,
  output logic                             PROG_RUNNING_O,
  output logic      [6:0]                  PROG_PROGRESS_O,
  output logic                             IRQ_O
);

  // Synchronisers: first stage read only by the second
  logic [1:0] lock_sync_q;
  logic [1:0] trig_sync_q;
  logic       trig_prev_q;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      lock_sync_q <= 2'h0;
      trig_sync_q <= 2'h0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      lock_sync_q <= {lock_sync_q[0], INTERLOCK_I};
      trig_sync_q <= {trig_sync_q[0], TRIGGER_I};
      trig_prev_q <= trig_sync_q[1];
    end
  end

  // Edge detector rests low like an idle pin, so leaving reset makes no false start
  wire contact_closed = lock_sync_q[1];
  wire trig_rise      = trig_sync_q[1] & ~trig_prev_q;

  // Control register
  logic inhibit_q;
  logic remote_q;
  logic out_cmd_q;
  logic trig_en_q;
  logic fault_set;

  // Register select shared by the write decoders
  function automatic logic reg_hit(input logic [ait_pkg::ADDR_W-1:0] addr,
                                   input logic [3:0]                 offset);
    return addr == offset;
  endfunction : reg_hit

  wire wr_ctrl = WR_I && reg_hit(ADDR_I, ait_pkg::REG_CTRL);
  wire wr_ist  = WR_I && reg_hit(ADDR_I, ait_pkg::REG_IRQ_ST);
  wire wr_imk  = WR_I && reg_hit(ADDR_I, ait_pkg::REG_IRQ_MK);

  wire launch_req = wr_ctrl & WDATA_I[ait_pkg::CTRL_LAUNCH_BIT];
  wire abort_req  = wr_ctrl & WDATA_I[ait_pkg::CTRL_ABORT_BIT];
  wire fclr_req   = wr_ctrl & WDATA_I[ait_pkg::CTRL_FLT_CLR_BIT];
  wire done_req   = wr_ctrl & WDATA_I[ait_pkg::CTRL_DONE_BIT];

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      {trig_en_q, out_cmd_q, remote_q, inhibit_q} <= ait_pkg::CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      inhibit_q <= WDATA_I[ait_pkg::CTRL_INHIBIT_BIT];
      remote_q  <= WDATA_I[ait_pkg::CTRL_REMOTE_BIT];
      out_cmd_q <= WDATA_I[ait_pkg::CTRL_OUT_EN_BIT];
      trig_en_q <= WDATA_I[ait_pkg::CTRL_TRIG_EN_BIT];
    end
    // A fault drops the command, so reclosing the contact cannot re-enable by itself
    else if (fault_set)
    begin
      out_cmd_q <= 1'b0;
    end
  end

  // Remote enable takes priority when both bits are set
  wire ait_pkg::ait_mode_e mode = remote_q  ? ait_pkg::AIT_MODE_REMOTE :
                                  inhibit_q ? ait_pkg::AIT_MODE_INHIBIT :
                                              ait_pkg::AIT_MODE_DISABLED;

  // Output enable decision
  logic output_d;
  logic output_q;
  logic fault_q;

  always_comb
  begin
    case (mode)
      ait_pkg::AIT_MODE_DISABLED: output_d = out_cmd_q;
      ait_pkg::AIT_MODE_INHIBIT:  output_d = out_cmd_q & contact_closed
                                             & ~fault_q;
      ait_pkg::AIT_MODE_REMOTE:   output_d = contact_closed;
      default:                    output_d = 1'b0;
    endcase
  end

  // Fault: contact opens while output on in inhibit behaviour
  assign fault_set = (mode == ait_pkg::AIT_MODE_INHIBIT) & output_q
                     & ~contact_closed;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      output_q <= 1'b0;
      fault_q  <= 1'b0;
    end
    else
    begin
      output_q <= output_d;
      fault_q  <= fault_set | (fault_q & ~fclr_req);
    end
  end

  // Transient program sequencer
  ait_pkg::ait_prog_e prog_q;
  ait_pkg::ait_prog_e prog_d;
  logic               start_d;

  always_comb
  begin
    prog_d  = prog_q;
    start_d = 1'b0;
    case (prog_q)
      ait_pkg::AIT_IDLE:
      begin
        if (launch_req)
          prog_d = trig_en_q ? ait_pkg::AIT_ARMED : ait_pkg::AIT_RUNNING;
        start_d = launch_req & ~trig_en_q;
      end
      ait_pkg::AIT_ARMED:
      begin
        if (abort_req)
          prog_d = ait_pkg::AIT_IDLE;
        else if (trig_rise)
        begin
          prog_d  = ait_pkg::AIT_RUNNING;
          start_d = 1'b1;
        end
      end
      ait_pkg::AIT_RUNNING:
      begin
        if (abort_req | done_req)
          prog_d = ait_pkg::AIT_IDLE;
      end
      default: prog_d = ait_pkg::AIT_IDLE;
    endcase
  end

  logic [6:0] progress_q;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      prog_q       <= ait_pkg::AIT_IDLE;
      PROG_START_O <= 1'b0;
      progress_q   <= ait_pkg::PROGRESS_ZERO;
    end
    else
    begin
      prog_q       <= prog_d;
      PROG_START_O <= start_d;
      if (prog_q == ait_pkg::AIT_RUNNING && done_req)
        progress_q <= ait_pkg::PROGRESS_FULL;
      else if (prog_d != ait_pkg::AIT_IDLE)
        progress_q <= ait_pkg::PROGRESS_ZERO;
    end
  end

  assign OUTPUT_ON_O     = output_q;
  assign FAULT_O         = fault_q;
  assign PROG_RUNNING_O  = (prog_q != ait_pkg::AIT_IDLE);
  assign PROG_PROGRESS_O = progress_q;

  // Interrupts: sticky status, write one to clear, set wins
  logic [ait_pkg::IRQ_N-1:0] ist_q;
  logic [ait_pkg::IRQ_N-1:0] imk_q;
  logic [ait_pkg::IRQ_N-1:0] ev;

  assign ev[ait_pkg::IRQ_FAULT_BIT] = fault_set & ~fault_q;
  assign ev[ait_pkg::IRQ_START_BIT] = start_d;
  assign ev[ait_pkg::IRQ_ARMED_BIT] = (prog_d == ait_pkg::AIT_ARMED)
                                      & (prog_q != ait_pkg::AIT_ARMED);

  genvar gi;
  generate
    for (gi = 0; gi < ait_pkg::IRQ_N; gi++)
    begin : g_irq
      always_ff @(posedge CLOCK_I)
      begin
        if (RST_I)
          ist_q[gi] <= 1'b0;
        else
          ist_q[gi] <= ev[gi] | (ist_q[gi] & ~(wr_ist & WDATA_I[gi]));
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      imk_q <= '0;
    else if (wr_imk)
      imk_q <= WDATA_I[ait_pkg::IRQ_N-1:0];
  end

  assign IRQ_O = |(ist_q & imk_q);

  // Read data, one cycle after the strobe
  logic [ait_pkg::DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    case (ADDR_I)
      ait_pkg::REG_CTRL:
        rd_mux[ait_pkg::CTRL_TRIG_EN_BIT:0] = {trig_en_q, out_cmd_q, remote_q, inhibit_q};
      ait_pkg::REG_STATUS:
      begin
        rd_mux[ait_pkg::ST_CONTACT_BIT] = contact_closed;
        rd_mux[ait_pkg::ST_OUTPUT_BIT]  = output_q;
        rd_mux[ait_pkg::ST_FAULT_BIT]   = fault_q;
        rd_mux[ait_pkg::ST_PROG_LSB+:2] = prog_q;
        rd_mux[ait_pkg::ST_PROG_LSB+2+:7] = progress_q;
      end
      ait_pkg::REG_IRQ_ST: rd_mux[ait_pkg::IRQ_N-1:0] = ist_q;
      ait_pkg::REG_IRQ_MK: rd_mux[ait_pkg::IRQ_N-1:0] = imk_q;
      default:             rd_mux = '0;
    endcase
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      RDATA_O <= '0;
    else
      RDATA_O <= RD_I ? rd_mux : '0;
  end

  // Assertions: interlock behaviour
  AST_DIS_FOLLOWS_CMD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (mode == ait_pkg::AIT_MODE_DISABLED) |=> (output_q == $past(out_cmd_q)))
    else $error("Disabled mode output does not follow command");
  AST_DIS_IGNORES_CONTACT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (mode == ait_pkg::AIT_MODE_DISABLED && $past(mode) == ait_pkg::AIT_MODE_DISABLED
     && $stable(out_cmd_q)) |=> $stable(output_q))
    else $error("Disabled mode output moved without a command change");
  AST_INH_NEEDS_CONTACT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ($past(mode) == ait_pkg::AIT_MODE_INHIBIT && !$past(contact_closed)) |-> !output_q)
    else $error("Inhibit mode output on with open contact");
  AST_INH_CLOSE_ALONE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (mode == ait_pkg::AIT_MODE_INHIBIT && !out_cmd_q) |=> !output_q)
    else $error("Inhibit mode output on without an enable command");
  AST_INH_FAULT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (mode == ait_pkg::AIT_MODE_INHIBIT && output_q && !contact_closed) |=> fault_q)
    else $error("Fault not raised on open contact");
  AST_FAULT_STICKY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (fault_q && !fclr_req) |=> fault_q)
    else $error("Fault dropped without a clear");
  AST_FAULT_DROPS_CMD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (fault_set && !wr_ctrl) |=> !out_cmd_q)
    else $error("Fault left the enable command set");
  AST_REMOTE_ON: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (mode == ait_pkg::AIT_MODE_REMOTE) |=> (output_q == $past(contact_closed)))
    else $error("Remote mode output does not follow contact");

  // Assertions: program sequencer and trigger
  AST_NO_START_IDLE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_IDLE && !launch_req) |=> !PROG_START_O)
    else $error("Start without launch");
  AST_ARM_NEEDS_TRIG_EN: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_IDLE) ##1 (prog_q == ait_pkg::AIT_ARMED) |-> $past(trig_en_q))
    else $error("Armed without trigger mode");
  AST_RUN_NO_START: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_RUNNING) |=> !PROG_START_O)
    else $error("Start pulse while already running");
  AST_IMMEDIATE_START: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_IDLE && launch_req && !trig_en_q) |=> PROG_START_O
    ##0 (prog_q == ait_pkg::AIT_RUNNING))
    else $error("Launch without trigger mode did not start at once");
  AST_EDGE_START: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_ARMED && !abort_req && trig_rise) |=> PROG_START_O
    ##0 (prog_q == ait_pkg::AIT_RUNNING))
    else $error("Armed program missed trigger edge");
  AST_ARMED_HOLDS: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_ARMED && !abort_req && !trig_rise)
    |=> (prog_q == ait_pkg::AIT_ARMED))
    else $error("Armed program left waiting without an edge");
  AST_ARMED_ZERO: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_ARMED)
    |-> (PROG_RUNNING_O && PROG_PROGRESS_O == ait_pkg::PROGRESS_ZERO))
    else $error("Armed state not running at zero");
  AST_DONE_FULL: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (prog_q == ait_pkg::AIT_RUNNING && done_req)
    |=> (!PROG_RUNNING_O && PROG_PROGRESS_O == ait_pkg::PROGRESS_FULL))
    else $error("Finished program not shown complete");
  AST_SYNC_DELAY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(TRIGGER_I) ##1 TRIGGER_I ##1 TRIGGER_I |-> trig_sync_q[1])
    else $error("Synchroniser delay wrong");
  AST_RISE_ONE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    trig_rise |=> !trig_rise)
    else $error("Edge detect longer than one cycle");
  AST_PULSE_ONE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    PROG_START_O |=> !PROG_START_O)
    else $error("Start pulse longer than one cycle");

  // Main scenarios
  COV_TRIG_START: cover property (@(posedge CLOCK_I) disable iff (RST_I)
    prog_q == ait_pkg::AIT_ARMED ##1 PROG_START_O);
  COV_FAULT: cover property (@(posedge CLOCK_I) disable iff (RST_I) $rose(fault_q));
  COV_REMOTE_ON: cover property (@(posedge CLOCK_I) disable iff (RST_I)
    mode == ait_pkg::AIT_MODE_REMOTE && $rose(output_q));
  COV_IMMEDIATE: cover property (@(posedge CLOCK_I) disable iff (RST_I)
    prog_q == ait_pkg::AIT_IDLE && launch_req && !trig_en_q);
  COV_DONE: cover property (@(posedge CLOCK_I) disable iff (RST_I)
    prog_q == ait_pkg::AIT_RUNNING && done_req);

endmodule : ait_top

// file: inc/ait_pkg.sv
// Constants and types of the interlock and trigger input block
package ait_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_ST = 4'h8;
  localparam logic [3:0] REG_IRQ_MK = 4'hc;

  // Control register fields
  localparam int unsigned CTRL_INHIBIT_BIT  = 0;
  localparam int unsigned CTRL_REMOTE_BIT   = 1;
  localparam int unsigned CTRL_OUT_EN_BIT   = 2;
  localparam int unsigned CTRL_TRIG_EN_BIT  = 3;
  localparam int unsigned CTRL_LAUNCH_BIT   = 4;
  localparam int unsigned CTRL_ABORT_BIT    = 5;
  localparam int unsigned CTRL_FLT_CLR_BIT  = 6;
  localparam int unsigned CTRL_DONE_BIT     = 7;
  localparam logic [3:0]  CTRL_RESET        = 4'h0;

  // Status register fields
  localparam int unsigned ST_CONTACT_BIT  = 0;
  localparam int unsigned ST_OUTPUT_BIT   = 1;
  localparam int unsigned ST_FAULT_BIT    = 2;
  localparam int unsigned ST_PROG_LSB     = 3;

  // Interrupt events
  localparam int unsigned IRQ_N         = 3;
  localparam int unsigned IRQ_FAULT_BIT = 0;
  localparam int unsigned IRQ_START_BIT = 1;
  localparam int unsigned IRQ_ARMED_BIT = 2;

  localparam logic [6:0] PROGRESS_ZERO = 7'h00;
  localparam logic [6:0] PROGRESS_FULL = 7'h64;

  typedef enum logic [1:0] {
    AIT_IDLE    = 2'b00,
    AIT_ARMED   = 2'b01,
    AIT_RUNNING = 2'b11
  } ait_prog_e;

  typedef enum logic [1:0] {
    AIT_MODE_DISABLED = 2'b00,
    AIT_MODE_INHIBIT  = 2'b01,
    AIT_MODE_REMOTE   = 2'b10
  } ait_mode_e;

endpackage : ait_pkg

// file: tb/ait_far_end.sv
// Model of the external contact closure and trigger source
`timescale 1ns/1ps

module ait_far_end (
  output logic interlock_o,
  output logic trigger_o
);
  initial
  begin
    interlock_o = 1'b0;
    trigger_o   = 1'b0;
  end

  // Contact moves off the clock grid, as a real switch would
  task automatic set_contact(input logic closed);
    #1.3 interlock_o = closed;
  endtask : set_contact

  // Source pulses whenever asked; acting on it is up to the device
  task automatic pulse_trigger(input int width_ns);
    #0.7 trigger_o = 1'b1;
    #(width_ns) trigger_o = 1'b0;
  endtask : pulse_trigger
endmodule : ait_far_end

// file: tb/tb_aux_interlock_trigger_inputs.sv
// Self-checking bench of the interlock and trigger input block
`timescale 1ns/1ps

module tb_aux_interlock_trigger_inputs;
  logic        clk;
  logic        rst;
  logic        ilk;
  logic        trg;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        out_on;
  logic        fault;
  logic        start;
  logic        running;
  logic [6:0]  progress;
  logic        irq;
  logic [31:0] d;
  logic [3:0]  v;
  logic [3:0]  corner [4];
  int          n_fail;
  int          check_count;
  int          seed;
  int          n;

  ait_top uut (.CLOCK_I(clk), .RST_I(rst), .INTERLOCK_I(ilk), .TRIGGER_I(trg),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .OUTPUT_ON_O(out_on), .FAULT_O(fault), .PROG_START_O(start),
    .PROG_RUNNING_O(running), .PROG_PROGRESS_O(progress), .IRQ_O(irq));

  ait_far_end far (.interlock_o(ilk), .trigger_o(trg));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Expected output level from {cmd, remote, inhibit} and contact
  function automatic logic exp_out(input logic [2:0] c, input logic k);
    if (c[1])
      return k;
    if (c[0])
      return k & c[2];
    return c[2];
  endfunction : exp_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] x);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    x = rdata;
  endtask : rd_reg

  // Pin to output takes three edges; six leaves margin
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask : settle

  task automatic trig_starts(output int c);
    c = 0;
    fork
      far.pulse_trigger(12);
      repeat (12)
      begin
        @(posedge clk);
        #1;
        if (start === 1'b1)
          c++;
      end
    join
  endtask : trig_starts

  task automatic finish_test;
    $display("Checks: %0d  failures: %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    #100us;
    n_fail++;
    $display("CHECK FAILED at %0t: run hung", $time);
    finish_test();
  end

  initial
  begin
    n_fail = 0;
    check_count = 0;
    seed = 19;
    corner = '{4'h8, 4'h5, 4'h1, 4'h4};
    rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ait_pkg::REG_STATUS, d);
    chk(d, 32'h0, "status after reset");
    rd_reg(4'h2, d);
    chk(d, 32'h0, "unmapped read");
    // Corners first, then random disabled and remote settings
    for (int i = 0; i < 20; i++)
    begin
      v = (i < 4) ? corner[i] : (4'($random(seed)) & 4'hd);
      far.set_contact(v[0]);
      wr_reg(ait_pkg::REG_CTRL, {29'h0, v[3:1]});
      settle();
      chk(out_on, exp_out(v[3:1], v[0]), "output level");
      rd_reg(4'($random(seed)) | 4'h1, d);
      chk(d, 32'h0, "random unmapped read");
    end
    far.set_contact(1'b0);
    wr_reg(ait_pkg::REG_CTRL, 32'h1);
    far.set_contact(1'b1);
    settle();
    chk(out_on, 1'b0, "closure alone");
    far.set_contact(1'b0);
    wr_reg(ait_pkg::REG_CTRL, 32'h5);
    settle();
    chk(out_on, 1'b0, "enable while open");
    far.set_contact(1'b1);
    wr_reg(ait_pkg::REG_CTRL, 32'h5);
    settle();
    chk(out_on, 1'b1, "enable while closed");
    wr_reg(ait_pkg::REG_IRQ_MK, 32'h1);
    far.set_contact(1'b0);
    settle();
    chk({irq, fault, out_on}, 3'b110, "opening while on");
    wr_reg(ait_pkg::REG_CTRL, 32'h40);
    wr_reg(ait_pkg::REG_IRQ_ST, 32'h1);
    settle();
    chk({irq, fault}, 2'b00, "fault cleared");
    wr_reg(ait_pkg::REG_CTRL, 32'h0);
    trig_starts(n);
    chk(n, 0, "trigger while idle");
    wr_reg(ait_pkg::REG_CTRL, 32'h8);
    wr_reg(ait_pkg::REG_CTRL, 32'h18);
    settle();
    chk({running, progress, start}, {1'b1, ait_pkg::PROGRESS_ZERO, 1'b0}, "armed");
    trig_starts(n);
    chk(n, 1, "start pulses");
    trig_starts(n);
    chk(n, 0, "trigger while running");
    wr_reg(ait_pkg::REG_CTRL, 32'h80);
    settle();
    chk(running, 1'b0, "done leaves running");
    chk(progress, ait_pkg::PROGRESS_FULL, "done progress");
    rd_reg(ait_pkg::REG_STATUS, d);
    chk(d, {20'h0, ait_pkg::PROGRESS_FULL, 5'h00}, "status after done");
    wr_reg(ait_pkg::REG_IRQ_ST, 32'h7);
    wr_reg(ait_pkg::REG_CTRL, 32'h10);
    rd_reg(ait_pkg::REG_IRQ_ST, d);
    chk(d, 32'h2, "launch without trigger mode starts");
    chk(running, 1'b1, "running after launch");
    wr_reg(ait_pkg::REG_CTRL, 32'h28);
    wr_reg(ait_pkg::REG_CTRL, 32'h18);
    wr_reg(ait_pkg::REG_CTRL, 32'h28);
    trig_starts(n);
    chk(n, 0, "trigger after abort");
    chk(running, 1'b0, "abort leaves running");
    far.set_contact(1'b1);
    wr_reg(ait_pkg::REG_CTRL, 32'h3);
    settle();
    chk(out_on, 1'b1, "remote over inhibit");
    finish_test();
  end
endmodule : tb_aux_interlock_trigger_inputs
